// file: btm_pkg.sv
// Purpose: Shared constants and types of the breaker trip manager
// Assumes: 125 MHz pclk, APB with 32-bit data
// Notes:   Hold time is kept in centiseconds
package btm_pkg;
   // -------------------------------------------------------------
   // Register map
   // -------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL     = 8'h00;
   localparam logic [7:0] ADDR_HOLD     = 8'h04;
   localparam logic [7:0] ADDR_SLOT     = 8'h08;
   localparam logic [7:0] ADDR_ILK      = 8'h0c;
   localparam logic [7:0] ADDR_EXT      = 8'h10;
   localparam logic [7:0] ADDR_STAT     = 8'h14;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h18;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h1c;

   // -------------------------------------------------------------
   // Fields and reset values
   // -------------------------------------------------------------
   localparam int          SEL_W       = 4;
   localparam int          NSRC        = 15;
   localparam int          NSLOT       = 7;
   localparam int          NILK        = 3;
   localparam int          HOLD_W      = 15;
   localparam int          NIRQ        = 4;
   localparam int          IRQ_OPEN    = 0;
   localparam int          IRQ_CLOSE   = 1;
   localparam int          IRQ_CBLK    = 2;
   localparam int          IRQ_OBLK    = 3;
   localparam int          CTRL_LATCH  = 0;
   localparam int          EXT_CLOSE_LSB = 0;
   localparam int          EXT_OPEN_LSB  = 4;
   localparam int          EXT_ACK_LSB   = 8;
   localparam int          ILK_OPEN_LSB  = 12;
   localparam logic [14:0] HOLD_DEF_CS = 15'h0014;
   localparam logic [14:0] HOLD_MAX_CS = 15'h7530;

   // -------------------------------------------------------------
   // Timing
   // -------------------------------------------------------------
   localparam longint CLK_HZ       = 125000000;
   localparam longint HOLD_LSB_MS  = 10;
   localparam int     CS_CYCLES    = int'(HOLD_LSB_MS * CLK_HZ / 1000);
   localparam int     PRE_W        = 21;

   typedef enum logic [1:0] {
      OPEN_IDLE,
      OPEN_HOLD,
      OPEN_STAY
   } btm_open_st_t;

   typedef struct packed {
      logic                           latch;
      logic [HOLD_W-1:0]              hold_cs;
      logic [NSLOT-1:0][SEL_W-1:0]    slot;
      logic [NILK-1:0][SEL_W-1:0]     open_ilk;
      logic [NILK-1:0][SEL_W-1:0]     close_ilk;
      logic [SEL_W-1:0]               ack;
      logic [SEL_W-1:0]               ext_open;
      logic [SEL_W-1:0]               ext_close;
   } btm_cfg_t;
endpackage : btm_pkg

// file: btm_pin_sync.sv
// Purpose: Three-stage pin synchroniser with agreement filter
// Assumes: Inputs asynchronous to pclk
// Notes:   Output moves only when stages two and three agree
module btm_pin_sync #(
   parameter int W = 15
) (
   // Clock and reset
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic         ce,
   // Data
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
         q    <= '0;
      end else if (ce) begin
         s1_q <= d;
         s2_q <= s1_q;
         s3_q <= s2_q;
         q    <= (s2_q & ~(s2_q ^ s3_q)) | (q & (s2_q ^ s3_q));
      end
   end
endmodule : btm_pin_sync

// file: btm_trip_mgr.sv
// Purpose: Breaker close/open command and trip manager, APB slave
// Assumes: trip_src from logic on pclk, dig_in from pins
// Notes:   Selector code 0 leaves an input unassigned
// Operation
// - Seven trip slots; rising assigned source opens breaker; unassigned slot inert
// - Open command held at least programmable time, 0-300 s, default 0.2 s
// - Latch setting, default off, keeps open command after cause ends
// - Three assignable close interlocks; any active one blocks close
// - Three assignable open interlocks; any active one blocks open
// - Assignable external close request issues close when it rises
// - Assignable external open request issues open when it rises
module btm_trip_mgr #(
   parameter int CS_CYCLES = btm_pkg::CS_CYCLES
) (
   // Clock, reset, enable
   input  wire logic                     pclk,
   input  wire logic                     presetn,
   input  wire logic                     ce,
   // APB
   input  wire logic                     psel,
   input  wire logic                     penable,
   input  wire logic                     pwrite,
   input  wire logic [7:0]               paddr,
   input  wire logic [31:0]              pwdata,
   output logic      [31:0]              prdata,
   output logic                          pready,
   output logic                          pslverr,
   // Sources
   input  wire logic [btm_pkg::NSRC-1:0] trip_src,
   input  wire logic [btm_pkg::NSRC-1:0] dig_in,
   // Breaker commands and interrupt
   output logic                          open_cmd,
   output logic                          close_cmd,
   output logic                          irq
);
   // -------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------
   function automatic logic pick(input logic [btm_pkg::NSRC-1:0] v,
                                 input logic [btm_pkg::SEL_W-1:0] c);
      logic r;
      r = 1'b0;
      if (c != '0) begin
         r = v[c - 4'h1];
      end
      return r;
   endfunction : pick

   btm_pkg::btm_cfg_t          cfg_q;
   btm_pkg::btm_open_st_t      st_q;
   btm_pkg::btm_open_st_t      st_d;
   logic [btm_pkg::NSRC-1:0]   di;
   logic [btm_pkg::NSLOT-1:0]  slot_lv;
   logic [btm_pkg::NSLOT-1:0]  slot_lv_q;
   logic                       ext_open_lv;
   logic                       ext_open_q;
   logic                       ext_close_lv;
   logic                       ext_close_q;
   logic                       ack_lv;
   logic                       open_ilk;
   logic                       close_ilk;
   logic                       open_rise;
   logic                       open_fire;
   logic                       trip_fire;
   logic                       ext_open_fire;
   logic                       close_rise;
   logic                       close_fire;
   logic                       cause;
   logic                       open_ok;
   logic                       close_ok;
   logic [btm_pkg::HOLD_W-1:0] cs_left_q;
   logic [btm_pkg::PRE_W-1:0]  pre_q;
   logic                       open_cmd_q;
   logic                       close_cmd_q;
   logic [btm_pkg::NIRQ-1:0]   irq_stat_q;
   logic [btm_pkg::NIRQ-1:0]   irq_mask_q;
   logic [btm_pkg::NIRQ-1:0]   ev;
   logic                       wr;
   logic                       rd_setup;
   logic                       mapped;
   logic [31:0]                rdata_d;
   logic [31:0]                prdata_q;

   btm_pin_sync #(
      .W       (btm_pkg::NSRC)
   ) u_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .ce      (ce),
      .d       (dig_in),
      .q       (di)
   );

   // -------------------------------------------------------------
   // Source selection
   // -------------------------------------------------------------
   always_comb begin
      for (int i = 0; i < btm_pkg::NSLOT; i++) begin
         slot_lv[i] = pick(trip_src, cfg_q.slot[i]);
      end
      open_ilk  = 1'b0;
      close_ilk = 1'b0;
      for (int i = 0; i < btm_pkg::NILK; i++) begin
         open_ilk  = open_ilk | pick(di, cfg_q.open_ilk[i]);
         close_ilk = close_ilk | pick(di, cfg_q.close_ilk[i]);
      end
   end

   assign ext_open_lv  = pick(di, cfg_q.ext_open);
   assign ext_close_lv = pick(di, cfg_q.ext_close);
   assign ack_lv       = pick(di, cfg_q.ack);
   assign cause        = (|slot_lv) | ext_open_lv;

   // Edge triggered: a source stuck high cannot retrigger the hold
   assign trip_fire     = |(slot_lv & ~slot_lv_q);
   assign ext_open_fire = ext_open_lv & ~ext_open_q;
   assign open_rise     = trip_fire | ext_open_fire;
   assign open_ok       = ~open_ilk;
   assign open_fire     = open_rise & open_ok;
   assign close_rise    = ext_close_lv & ~ext_close_q;
   assign close_ok      = ~close_ilk;
   // Open has priority over a concurrent close
   assign close_fire    = close_rise & close_ok
                        & (st_q == btm_pkg::OPEN_IDLE) & ~open_fire;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         slot_lv_q   <= '0;
         ext_open_q  <= 1'b0;
         ext_close_q <= 1'b0;
      end else if (ce) begin
         slot_lv_q   <= slot_lv;
         ext_open_q  <= ext_open_lv;
         ext_close_q <= ext_close_lv;
      end
   end

   // -------------------------------------------------------------
   // Open command sequencer
   // -------------------------------------------------------------
   always_comb begin
      st_d = st_q;
      case (st_q)
         btm_pkg::OPEN_IDLE: begin
            if (open_fire) begin
               st_d = btm_pkg::OPEN_HOLD;
            end
         end
         btm_pkg::OPEN_HOLD: begin
            if (open_fire) begin
               st_d = btm_pkg::OPEN_HOLD;
            end else if (cs_left_q == '0) begin
               st_d = (cause || cfg_q.latch) ? btm_pkg::OPEN_STAY
                                             : btm_pkg::OPEN_IDLE;
            end
         end
         btm_pkg::OPEN_STAY: begin
            if (open_fire) begin
               st_d = btm_pkg::OPEN_HOLD;
            end else if (!cause && (!cfg_q.latch || ack_lv)) begin
               st_d = btm_pkg::OPEN_IDLE;
            end
         end
         default: st_d = btm_pkg::OPEN_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q       <= btm_pkg::OPEN_IDLE;
         open_cmd_q <= 1'b0;
      end else if (ce) begin
         st_q       <= st_d;
         open_cmd_q <= (st_d != btm_pkg::OPEN_IDLE);
      end
   end

   // Centisecond prescaler and hold countdown
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pre_q     <= '0;
         cs_left_q <= '0;
      end else if (ce) begin
         if (open_fire) begin
            pre_q     <= '0;
            cs_left_q <= cfg_q.hold_cs;
         end else if (st_q == btm_pkg::OPEN_HOLD && cs_left_q != '0) begin
            if (pre_q == btm_pkg::PRE_W'(CS_CYCLES - 1)) begin
               pre_q     <= '0;
               cs_left_q <= cs_left_q - 15'h0001;
            end else begin
               pre_q <= pre_q + 21'h000001;
            end
         end
      end
   end

   // -------------------------------------------------------------
   // Close command
   // -------------------------------------------------------------
   // Close stands while the request stays high; open cancels it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         close_cmd_q <= 1'b0;
      end else if (ce) begin
         if (st_d != btm_pkg::OPEN_IDLE) begin
            close_cmd_q <= 1'b0;
         end else if (close_fire) begin
            close_cmd_q <= 1'b1;
         end else if (!ext_close_lv) begin
            close_cmd_q <= 1'b0;
         end
      end
   end

   assign open_cmd  = open_cmd_q;
   assign close_cmd = close_cmd_q;

   // -------------------------------------------------------------
   // APB registers
   // -------------------------------------------------------------
   assign wr       = psel & penable & pwrite & ce;
   assign rd_setup = psel & ~penable & ~pwrite & ce;
   // Registers never stall; a frozen block stalls the bus instead
   assign pready   = ce;
   assign prdata   = prdata_q;

   always_comb begin
      mapped  = 1'b1;
      rdata_d = '0;
      case (paddr)
         btm_pkg::ADDR_CTRL:     rdata_d[btm_pkg::CTRL_LATCH] = cfg_q.latch;
         btm_pkg::ADDR_HOLD:     rdata_d[14:0] = cfg_q.hold_cs;
         btm_pkg::ADDR_SLOT:     rdata_d[27:0] = cfg_q.slot;
         btm_pkg::ADDR_ILK:      rdata_d[23:0] = {cfg_q.open_ilk,
                                                  cfg_q.close_ilk};
         btm_pkg::ADDR_EXT:      rdata_d[11:0] = {cfg_q.ack, cfg_q.ext_open,
                                                  cfg_q.ext_close};
         btm_pkg::ADDR_STAT:     rdata_d[4:0]  = {cause, st_q,
                                                  close_cmd_q, open_cmd_q};
         btm_pkg::ADDR_IRQ_STAT: rdata_d[3:0]  = irq_stat_q;
         btm_pkg::ADDR_IRQ_MASK: rdata_d[3:0]  = irq_mask_q;
         default:                mapped = 1'b0;
      endcase
   end

   assign pslverr = psel & penable & ~mapped;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= '0;
      end else if (rd_setup) begin
         prdata_q <= rdata_d;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_q         <= '0;
         cfg_q.hold_cs <= btm_pkg::HOLD_DEF_CS;
         irq_mask_q    <= '0;
      end else if (wr && mapped) begin
         case (paddr)
            btm_pkg::ADDR_CTRL: cfg_q.latch <= pwdata[btm_pkg::CTRL_LATCH];
            btm_pkg::ADDR_HOLD: begin
               // Out of range values clip to the 300 s ceiling
               cfg_q.hold_cs <= (pwdata[14:0] > btm_pkg::HOLD_MAX_CS)
                              ? btm_pkg::HOLD_MAX_CS : pwdata[14:0];
            end
            btm_pkg::ADDR_SLOT: cfg_q.slot <= pwdata[27:0];
            btm_pkg::ADDR_ILK: begin
               cfg_q.close_ilk <= pwdata[11:0];
               cfg_q.open_ilk  <= pwdata[23:btm_pkg::ILK_OPEN_LSB];
            end
            btm_pkg::ADDR_EXT: begin
               cfg_q.ext_close <= pwdata[btm_pkg::EXT_CLOSE_LSB +: 4];
               cfg_q.ext_open  <= pwdata[btm_pkg::EXT_OPEN_LSB +: 4];
               cfg_q.ack       <= pwdata[btm_pkg::EXT_ACK_LSB +: 4];
            end
            btm_pkg::ADDR_IRQ_MASK: irq_mask_q <= pwdata[3:0];
            default: ;
         endcase
      end
   end

   // -------------------------------------------------------------
   // Interrupts
   // -------------------------------------------------------------
   always_comb begin
      ev                     = '0;
      ev[btm_pkg::IRQ_OPEN]  = open_fire;
      ev[btm_pkg::IRQ_CLOSE] = close_fire;
      ev[btm_pkg::IRQ_CBLK]  = close_rise & close_ilk;
      ev[btm_pkg::IRQ_OBLK]  = open_rise & open_ilk;
   end

   // Set wins over a same-cycle write-one clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_stat_q <= '0;
      end else if (ce) begin
         if (wr && paddr == btm_pkg::ADDR_IRQ_STAT) begin
            irq_stat_q <= (irq_stat_q & ~pwdata[3:0]) | ev;
         end else begin
            irq_stat_q <= irq_stat_q | ev;
         end
      end
   end

   assign irq = |(irq_stat_q & irq_mask_q);

   // -------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_latched_wait;
      ce && st_q == btm_pkg::OPEN_STAY && cfg_q.latch;
   endsequence
   sequence s_ack_clear;
      ack_lv && !cause && !open_fire;
   endsequence

   AST_SLOT_FIRES: assert property (ce && trip_fire && open_ok |=> open_cmd_q)
      else $error("trip slot edge did not raise open");
   AST_HOLD_MIN: assert property ($fell(open_cmd_q) |-> $past(cs_left_q) == 0)
      else $error("open dropped before hold expired");
   AST_LATCH_STAYS: assert property (s_latched_wait ##0 !ack_lv |=> open_cmd_q)
      else $error("latched open released without ack");
   AST_CLOSE_ILK: assert property ($rose(close_cmd_q) |-> $past(close_ok))
      else $error("close issued while interlocked");
   AST_OPEN_ILK: assert property ($rose(open_cmd_q) |-> $past(open_ok))
      else $error("open issued while interlocked");
   AST_CLOSE_REQ: assert property (ce && close_fire |=> close_cmd_q)
      else $error("close request not carried out");
   AST_EXT_OPEN: assert property (
      ce && ext_open_fire && open_ok |=> open_cmd_q)
      else $error("external open request not carried out");
   AST_CE_FREEZE: assert property (
      !ce |=> $stable(cs_left_q) && $stable(open_cmd_q))
      else $error("hold state moved while clock enable low");
   AST_ACK_CLEAR: assert property (s_latched_wait ##0 s_ack_clear |=> !open_cmd_q)
      else $error("ack did not clear latched open");
endmodule : btm_trip_mgr

// file: btm_breaker_model.sv
// Purpose: Behavioural breaker behind the open and close relays
// Assumes: Relay commands are levels sampled on pclk
// Notes:   Travel takes TRAVEL ticks; open coil wins over close
module btm_breaker_model #(
   parameter int TRAVEL = 3
) (
   // Clock
   input  wire logic pclk,
   // Relay coils
   input  wire logic open_cmd,
   input  wire logic close_cmd,
   // Auxiliary contact, high when closed
   output logic      closed
);
   // -------------------------------------------------------------
   // Mechanism
   // -------------------------------------------------------------
   logic target;
   int   cnt = 0;
   initial closed = 1'b0;
   // A trip must never be overridden by a close that is still held
   assign target = (open_cmd === 1'b1) ? 1'b0 :
                   (close_cmd === 1'b1) ? 1'b1 : closed;
   always @(posedge pclk) begin
      if (target == closed) begin
         cnt <= 0;
      end else if (cnt >= TRAVEL - 1) begin
         closed <= target;
         cnt <= 0;
      end else begin
         cnt <= cnt + 1;
      end
   end
endmodule : btm_breaker_model

// file: btm_trip_mgr_tb.sv
// Purpose: Self-checking bench of the breaker trip manager
// Assumes: CS_CYCLES set to 4, so one centisecond is 4 ticks
// Notes:   Digital inputs need about five ticks to reach the logic
module btm_trip_mgr_tb;
   timeunit 1ns;
   timeprecision 1ps;
   // -------------------------------------------------------------
   // Signals
   // -------------------------------------------------------------
   localparam int CSC = 4;
   logic        pclk     = 1'b0;
   logic        presetn  = 1'b0;
   logic        ce       = 1'b1;
   logic        psel     = 1'b0;
   logic        penable  = 1'b0;
   logic        pwrite   = 1'b0;
   logic [7:0]  paddr    = 8'h00;
   logic [31:0] pwdata   = 32'h0;
   logic [14:0] trip_src = 15'h0;
   logic [14:0] dig_in   = 15'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        open_cmd;
   logic        close_cmd;
   logic        irq;
   logic        brk_closed;
   logic [31:0] rd;
   logic        err;
   int          n_mismatch = 0;
   int          n_checks   = 0;

   always #4 pclk = ~pclk;

   btm_trip_mgr #(.CS_CYCLES(CSC)) uut (
      .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .trip_src(trip_src), .dig_in(dig_in),
      .open_cmd(open_cmd), .close_cmd(close_cmd), .irq(irq));

   btm_breaker_model brk (
      .pclk(pclk), .open_cmd(open_cmd), .close_cmd(close_cmd),
      .closed(brk_closed));

   // -------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------
   task automatic chk_w(input string nm, input logic [31:0] e,
                        input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask : chk_w

   task automatic chk_b(input string nm, input logic e, input logic g);
      chk_w(nm, {31'h0, e}, {31'h0, g});
   endtask : chk_b

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : give_verdict

   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask : cyc

   // Always lets one edge pass, so no signal is driven twice at once
   task automatic wait_b(input string nm, ref logic s, input logic e,
                         input int lim);
      int n;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (s !== e && n < lim);
      chk_b(nm, e, s);
   endtask : wait_b

   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      chk_b("pready", 1'b1, pready);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr

   task automatic rd_chk(input string nm, input logic [7:0] a,
                         input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk_w(nm, e, rd);
   endtask : rd_chk

   // -------------------------------------------------------------
   // Scenarios
   // -------------------------------------------------------------
   task automatic t_reset();
      logic [7:0] a;
      chk_b("open_cmd", 1'b0, open_cmd);
      chk_b("irq", 1'b0, irq);
      for (int i = 0; i < 8; i++) begin
         a = 8'(4 * i);
         rd_chk("reg_reset", a, (a == btm_pkg::ADDR_HOLD) ?
                32'(btm_pkg::HOLD_DEF_CS) : 32'h0);
      end
      apb(1'b0, 8'h40, 32'h0);
      chk_b("unmapped_err", 1'b1, err);
      wr(btm_pkg::ADDR_STAT, 32'hff);
      rd_chk("stat_ro", btm_pkg::ADDR_STAT, 32'h0);
      $display("test reset done");
   endtask : t_reset

   task automatic t_slots();
      wr(btm_pkg::ADDR_HOLD, 32'h0);
      for (int i = 0; i < btm_pkg::NSLOT; i++) begin
         wr(btm_pkg::ADDR_SLOT, 32'(i + 1) << (4 * i));
         trip_src[14] <= 1'b1;
         cyc(4);
         chk_b("unassigned", 1'b0, open_cmd);
         trip_src <= 15'h0001 << i;
         wait_b("slot_open", open_cmd, 1'b1, 3);
         trip_src <= 15'h0;
         wait_b("slot_end", open_cmd, 1'b0, 10);
      end
      $display("test slots done");
   endtask : t_slots

   task automatic t_hold();
      int n;
      wr(btm_pkg::ADDR_HOLD, 32'h7fff);
      rd_chk("hold_clip", btm_pkg::ADDR_HOLD,
             32'(btm_pkg::HOLD_MAX_CS));
      wr(btm_pkg::ADDR_HOLD, 32'(btm_pkg::HOLD_DEF_CS));
      wr(btm_pkg::ADDR_SLOT, 32'h1);
      trip_src[0] <= 1'b1;
      @(posedge pclk);
      trip_src[0] <= 1'b0;
      wait_b("hold_rise", open_cmd, 1'b1, 3);
      n = 0;
      while (open_cmd === 1'b1 && n < 300) begin
         @(posedge pclk);
         n++;
      end
      chk_b("hold_span", 1'b1, n >= 20 * CSC - 1 &&
            n <= 20 * CSC + 4);
      $display("test hold done");
   endtask : t_hold

   task automatic t_latch();
      wr(btm_pkg::ADDR_HOLD, 32'h2);
      wr(btm_pkg::ADDR_CTRL, 32'h1);
      wr(btm_pkg::ADDR_EXT, 32'h100);
      trip_src[0] <= 1'b1;
      @(posedge pclk);
      trip_src[0] <= 1'b0;
      wait_b("latch_rise", open_cmd, 1'b1, 3);
      cyc(30);
      chk_b("latched", 1'b1, open_cmd);
      rd_chk("stat_latched", btm_pkg::ADDR_STAT, 32'h9);
      trip_src[0] <= 1'b1;
      cyc(20);
      dig_in[0] <= 1'b1;
      cyc(10);
      chk_b("ack_cause", 1'b1, open_cmd);
      trip_src[0] <= 1'b0;
      wait_b("ack_clear", open_cmd, 1'b0, 10);
      dig_in[0] <= 1'b0;
      wr(btm_pkg::ADDR_CTRL, 32'h0);
      wr(btm_pkg::ADDR_HOLD, 32'h0);
      $display("test latch done");
   endtask : t_latch

   task automatic t_open_ilk();
      wr(btm_pkg::ADDR_IRQ_STAT, 32'hf);
      wr(btm_pkg::ADDR_ILK, 32'h2000);
      dig_in[1] <= 1'b1;
      cyc(8);
      trip_src[0] <= 1'b1;
      cyc(6);
      chk_b("open_blocked", 1'b0, open_cmd);
      trip_src[0] <= 1'b0;
      rd_chk("irq_oblk", btm_pkg::ADDR_IRQ_STAT, 32'h8);
      wr(btm_pkg::ADDR_IRQ_MASK, 32'h8);
      wait_b("irq_on", irq, 1'b1, 3);
      wr(btm_pkg::ADDR_IRQ_MASK, 32'h0);
      wait_b("irq_masked", irq, 1'b0, 3);
      wr(btm_pkg::ADDR_IRQ_STAT, 32'h8);
      rd_chk("irq_w1c", btm_pkg::ADDR_IRQ_STAT, 32'h0);
      wr(btm_pkg::ADDR_ILK, 32'h0);
      dig_in[1] <= 1'b0;
      $display("test open interlock done");
   endtask : t_open_ilk

   task automatic t_close();
      wr(btm_pkg::ADDR_EXT, 32'h3);
      dig_in[2] <= 1'b1;
      wait_b("close", close_cmd, 1'b1, 10);
      wait_b("brk_closed", brk_closed, 1'b1, 10);
      dig_in[2] <= 1'b0;
      wait_b("close_end", close_cmd, 1'b0, 10);
      wr(btm_pkg::ADDR_ILK, 32'h4);
      wr(btm_pkg::ADDR_IRQ_STAT, 32'hf);
      dig_in[3] <= 1'b1;
      cyc(8);
      dig_in[2] <= 1'b1;
      cyc(10);
      chk_b("close_blocked", 1'b0, close_cmd);
      rd_chk("irq_cblk", btm_pkg::ADDR_IRQ_STAT, 32'h4);
      dig_in[2] <= 1'b0;
      dig_in[3] <= 1'b0;
      wr(btm_pkg::ADDR_ILK, 32'h0);
      $display("test close done");
   endtask : t_close

   task automatic t_ext_open();
      wr(btm_pkg::ADDR_EXT, 32'h50);
      dig_in[4] <= 1'b1;
      wait_b("ext_open", open_cmd, 1'b1, 10);
      wait_b("brk_open", brk_closed, 1'b0, 10);
      dig_in[4] <= 1'b0;
      wait_b("ext_end", open_cmd, 1'b0, 10);
      $display("test ext open done");
   endtask : t_ext_open

   // Hold countdown must stop while the block is frozen
   task automatic t_freeze();
      wr(btm_pkg::ADDR_HOLD, 32'h1);
      trip_src[0] <= 1'b1;
      @(posedge pclk);
      trip_src[0] <= 1'b0;
      wait_b("frz_rise", open_cmd, 1'b1, 3);
      ce <= 1'b0;
      cyc(20);
      chk_b("frz_hold", 1'b1, open_cmd);
      chk_b("frz_pready", 1'b0, pready);
      ce <= 1'b1;
      wait_b("frz_end", open_cmd, 1'b0, 10);
      $display("test freeze done");
   endtask : t_freeze

   // -------------------------------------------------------------
   // Sequence and watchdog
   // -------------------------------------------------------------
   initial begin
      cyc(20);
      presetn <= 1'b1;
      t_reset();
      t_slots();
      t_hold();
      t_latch();
      t_open_ilk();
      t_close();
      t_ext_open();
      t_freeze();
      give_verdict();
   end

   // Whole run is near 500 ticks
   initial begin
      cyc(20000);
      n_mismatch++;
      give_verdict();
   end
endmodule : btm_trip_mgr_tb
